// ---- dv/gpio_pin_model.sv ----
// Model of the board around both ports: drivers on both, pull-ups and floating lines on port B.
module gpio_pin_model (
    input wire logic mclk,
    input wire logic [5:0] aOut,
    input wire logic [5:0] aOe_n,
    input wire logic [5:0] aExt,
    input wire logic [7:0] bOut,
    input wire logic [7:0] bOe_n,
    input wire logic [7:0] bPull,
    input wire logic [7:0] bExt,
    input wire logic [7:0] bExtEn,
    output logic [5:0] aPin,
    output logic [7:0] bPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Pin levels.
    // ======================================================================
    // A line with no driver and no pull-up changes every cycle, so a design
    // that reads it cannot pass by luck of the simulator's settling.
    logic [7:0] flt = 8'h55;
    always @(posedge mclk) begin
        flt <= ~flt;
    end
    always_comb begin
        aPin = (~aOe_n & aOut) | (aOe_n & aExt);
        bPin = (~bOe_n & bOut) | (bOe_n & bExtEn & bExt)
            | (bOe_n & ~bExtEn & (bPull | flt));
    end
endmodule : gpio_pin_model

// ---- dv/gpio_port_props.sv ----
// Port-level checker of the dual general-purpose port block.
module gpio_port_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic otherReset,
    input wire logic [7:0] regAddr,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic [gpio_pkg::PORT_A_WIDTH-1:0] portAOut,
    input wire logic [gpio_pkg::PORT_A_WIDTH-1:0] portAOe_n,
    input wire logic [gpio_pkg::PORT_B_WIDTH-1:0] portBIn,
    input wire logic [gpio_pkg::PORT_B_WIDTH-1:0] portBOut,
    input wire logic [gpio_pkg::PORT_B_WIDTH-1:0] portBOe_n,
    input wire logic [gpio_pkg::PORT_B_WIDTH-1:0] portBPullupEn,
    input wire logic extInterrupt,
    input wire logic portChangeIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_pkg::*;
    // ======================================================================
    // Properties.
    // ======================================================================
    // A write to interrupt control or a reset is the only way to drop the flag.
    logic clr;
    assign clr = otherReset | (regWrStb & (regAddr == INTERRUPT_CONTROL_OFS));
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_pullup_out;
        (portBPullupEn & ~portBOe_n) == 8'h00;
    endproperty
    a_pullup_out: assert property (p_pullup_out)
        else $error("pull-up on a driven pin");
    property p_por_values;
        $fell(rst) |-> portBOe_n == 8'hff && portAOe_n == 6'h3f
            && portBPullupEn == 8'h00;
    endproperty
    a_por_values: assert property (p_por_values)
        else $error("wrong pin state after power-on reset");
    property p_other_dir;
        $fell(otherReset) |=> portBOe_n == 8'hff && portAOe_n == 6'h3f;
    endproperty
    a_other_dir: assert property (p_other_dir)
        else $error("pins still driven after other reset");
    property p_dirb_read;
        regRdStb && regAddr == PORT_B_DIRECTION_OFS && !otherReset
            |=> regRdData == portBOe_n;
    endproperty
    a_dirb_read: assert property (p_dirb_read)
        else $error("direction B disagrees with pin enables");
    property p_port_a_pins_hi;
        regRdStb && (regAddr == PORT_A_PINS_OFS
            || regAddr == PORT_A_DIRECTION_OFS) |=> regRdData[7:6] == 2'b00;
    endproperty
    a_port_a_pins_hi: assert property (p_port_a_pins_hi)
        else $error("port A upper bits read nonzero");
    property p_od_low;
        portAOut[TIMER_CLOCK_BIT] == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain pin driven high");
    property p_flag_hold;
        portChangeIrq && !clr && !$past(clr) |=> portChangeIrq;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("change flag dropped on its own");
    property p_sync_lat;
        !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)
            |-> extInterrupt == $past(portBIn[EXT_INTERRUPT_BIT], 3);
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("interrupt input latency wrong");
    property p_keep_latch;
        otherReset |=> $stable(portBOut);
    endproperty
    a_keep_latch: assert property (p_keep_latch)
        else $error("latch changed by other reset");
endmodule : gpio_port_props

bind dual_gpio_port gpio_port_props chk (.mclk(mclk), .rst(rst),
    .otherReset(otherReset), .regAddr(regAddr), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .portAOut(portAOut),
    .portAOe_n(portAOe_n), .portBIn(portBIn), .portBOut(portBOut),
    .portBOe_n(portBOe_n), .portBPullupEn(portBPullupEn),
    .extInterrupt(extInterrupt), .portChangeIrq(portChangeIrq));

// ---- dv/testbench.sv ----
// Self-checking bench of the dual general-purpose port block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic otherReset = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [7:0] regRdData;
    logic [5:0] portAIn, portAOut, portAOe_n;
    logic [5:0] aExt = 6'h00;
    logic [7:0] portBIn, portBOut, portBOe_n, portBPullupEn;
    logic [7:0] bExt = 8'h00;
    logic [7:0] bExtEn = 8'hff;
    logic extInterrupt, portChangeIrq;
    logic timerExtClock, slaveSelect_n, progClock, progData;
    int n_fail = 0;
    int n_compared = 0;
    int waitCount;
    row_t rows [6] = '{'{8'h81, 8'h7f, 8'h7f}, '{8'h86, 8'hf0, 8'hf0},
        '{8'h85, 8'hff, 8'h3f}, '{8'h0b, 8'h08, 8'h08},
        '{8'h20, 8'h55, 8'h00}, '{8'h85, 8'hc0, 8'h00}};
    always #4 mclk = ~mclk;
    dual_gpio_port uut (.mclk(mclk), .rst(rst), .otherReset(otherReset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .portAIn(portAIn),
        .portAOut(portAOut), .portAOe_n(portAOe_n), .portBIn(portBIn),
        .portBOut(portBOut), .portBOe_n(portBOe_n),
        .portBPullupEn(portBPullupEn), .timerExtClock(timerExtClock),
        .slaveSelect_n(slaveSelect_n), .extInterrupt(extInterrupt),
        .progClock(progClock), .progData(progData),
        .portChangeIrq(portChangeIrq));
    gpio_pin_model pins (.mclk(mclk), .aOut(portAOut), .aOe_n(portAOe_n),
        .aExt(aExt), .bOut(portBOut), .bOe_n(portBOe_n),
        .bPull(portBPullupEn), .bExt(bExt), .bExtEn(bExtEn),
        .aPin(portAIn), .bPin(portBIn));
    // ======================================================================
    // Tasks.
    // ======================================================================
    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1;
        check(regRdData, exp);
    endtask : rdchk
    task automatic check_resets();
        rdchk(TIMER_AND_PULLUP_OPTIONS_OFS, 8'hff);
        rdchk(PORT_A_DIRECTION_OFS, 8'h3f);
        rdchk(PORT_B_DIRECTION_OFS, 8'hff);
        check(portBPullupEn, 8'h00);
    endtask : check_resets
    // ======================================================================
    // Main sequence.
    // ======================================================================
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        check_resets();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].q);
        end
        check(portBPullupEn, 8'hf0);
        check(portBOe_n, 8'hf0);
        wr(PORT_B_PINS_OFS, 8'ha5);
        bExt <= 8'h30;
        cycles(5);
        check(portBOut, 8'ha5);
        rdchk(PORT_B_PINS_OFS, 8'h35);
        wr(PORT_A_PINS_OFS, 8'hff);
        aExt <= 6'h10;
        cycles(5);
        check({2'b00, portAOe_n}, 8'h10);
        check({2'b00, portAOut}, 8'h2f);
        check({7'h00, timerExtClock}, 8'h01);
        check({7'h00, slaveSelect_n}, 8'h01);
        rdchk(PORT_A_PINS_OFS, 8'h3f);
        wr(INTERRUPT_CONTROL_OFS, 8'h08);
        cycles(4);
        check({7'h00, portChangeIrq}, 8'h00);
        bExt <= 8'h70;
        waitCount = 0;
        while (portChangeIrq !== 1'b1 && waitCount < 20) begin
            cycles(1);
            waitCount++;
        end
        check({7'h00, portChangeIrq}, 8'h01);
        if (waitCount == 20) begin
            n_fail++;
            summarize();
        end
        wr(INTERRUPT_CONTROL_OFS, 8'h08);
        cycles(3);
        rdchk(INTERRUPT_CONTROL_OFS, 8'h09);
        rdchk(PORT_B_PINS_OFS, 8'h75);
        check({6'h00, progData, progClock}, 8'h01);
        wr(INTERRUPT_CONTROL_OFS, 8'h08);
        cycles(3);
        check({7'h00, portChangeIrq}, 8'h00);
        // Port B is left unread from here while the detector runs.
        wr(PORT_B_DIRECTION_OFS, 8'h1f);
        cycles(6);
        rdchk(INTERRUPT_CONTROL_OFS, 8'h08);
        check(portBPullupEn, 8'h1f);
        bExtEn <= 8'hfe;
        cycles(4);
        check({7'h00, extInterrupt}, 8'h01);
        @(posedge mclk);
        otherReset <= 1'b1;
        repeat (2) @(posedge mclk);
        otherReset <= 1'b0;
        cycles(3);
        check(portBOut, 8'ha5);
        check(portBOe_n, 8'hff);
        rdchk(TIMER_AND_PULLUP_OPTIONS_OFS, 8'hff);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_resets();
        summarize();
    end
endmodule : testbench

// ---- rtl/dual_gpio_port.sv ----
// Two general-purpose ports, pull-ups on port B, and a change detector.
//
// Chosen here: the address-and-strobe port.
module dual_gpio_port #(
    parameter bit HAS_PORT_A_BIT5 = 1'b1,
    parameter bit EARLY_SILICON = 1'b0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic otherReset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic [gpio_pkg::PORT_A_WIDTH-1:0] portAIn,
    output logic [gpio_pkg::PORT_A_WIDTH-1:0] portAOut,
    output logic [gpio_pkg::PORT_A_WIDTH-1:0] portAOe_n,
    input wire logic [gpio_pkg::PORT_B_WIDTH-1:0] portBIn,
    output logic [gpio_pkg::PORT_B_WIDTH-1:0] portBOut,
    output logic [gpio_pkg::PORT_B_WIDTH-1:0] portBOe_n,
    output logic [gpio_pkg::PORT_B_WIDTH-1:0] portBPullupEn,
    output logic timerExtClock,
    output logic slaveSelect_n,
    output logic extInterrupt,
    output logic progClock,
    output logic progData,
    output logic portChangeIrq
);
    import gpio_pkg::*;

    // ======================================================================
    // Register state.
    // ======================================================================
    logic [PORT_A_WIDTH-1:0] portALatch_r;
    logic [PORT_B_WIDTH-1:0] portBLatch_r;
    logic [PORT_A_WIDTH-1:0] portADir_r;
    logic [PORT_B_WIDTH-1:0] portBDir_r;
    logic [7:0] options_r;
    logic portChangeFlag_r;
    logic portChangeEnable_r;
    logic [3:0] snapshot_r;

    logic [PORT_A_WIDTH-1:0] portAMeta_r;
    logic [PORT_A_WIDTH-1:0] portASync_r;
    logic [PORT_B_WIDTH-1:0] portBMeta_r;
    logic [PORT_B_WIDTH-1:0] portBSync_r;

    logic [PORT_A_WIDTH-1:0] portAImpl;
    logic [PORT_A_WIDTH-1:0] portAPins;
    logic [3:0] mismatch;
    logic anyMismatch;
    logic wrPortA;
    logic wrPortB;
    logic rdPortB;
    logic wrIntCtl;
    logic wrOptions;
    logic wrDirA;
    logic wrDirB;
    logic changeSet;
    logic [7:0] rdData_nxt;

    // ======================================================================
    // Pin synchronisers.
    // ======================================================================
    // Pins are asynchronous to mclk, so two stages precede any use.
    always_ff @(posedge mclk) begin
        if (rst) begin
            portAMeta_r <= '0;
            portASync_r <= '0;
        end else begin
            portAMeta_r <= portAIn;
            portASync_r <= portAMeta_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            portBMeta_r <= '0;
            portBSync_r <= '0;
        end else begin
            portBMeta_r <= portBIn;
            portBSync_r <= portBMeta_r;
        end
    end

    // ======================================================================
    // Address decode.
    // ======================================================================
    // Decodes are plain gates, so a strobe acts at the edge that samples it.
    assign wrPortA = regWrStb && (regAddr == PORT_A_PINS_OFS);
    assign wrPortB = regWrStb && (regAddr == PORT_B_PINS_OFS);
    assign rdPortB = regRdStb && (regAddr == PORT_B_PINS_OFS);
    assign wrIntCtl = regWrStb && (regAddr == INTERRUPT_CONTROL_OFS);
    assign wrOptions = regWrStb && (regAddr == TIMER_AND_PULLUP_OPTIONS_OFS);
    assign wrDirA = regWrStb && (regAddr == PORT_A_DIRECTION_OFS);
    assign wrDirB = regWrStb && (regAddr == PORT_B_DIRECTION_OFS);

    // The missing bit of the five-bit variant is masked everywhere.
    assign portAImpl = HAS_PORT_A_BIT5 ? '1 : 6'h1f;
    assign portAPins = portASync_r & portAImpl;

    // ======================================================================
    // Data latches.
    // ======================================================================
    // Only power-on reset clears the latches; other resets leave them alone.
    always_ff @(posedge mclk) begin
        if (rst) begin
            portALatch_r <= PORT_A_LATCH_RESET;
        end else if (wrPortA) begin
            portALatch_r <= regWrData[PORT_A_WIDTH-1:0] & portAImpl;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            portBLatch_r <= PORT_B_LATCH_RESET;
        end else if (wrPortB) begin
            portBLatch_r <= regWrData;
        end
    end

    // ======================================================================
    // Direction and option registers.
    // ======================================================================
    // Any reset parks every pin as an input with its pull-up off.
    always_ff @(posedge mclk) begin
        if (rst || otherReset) begin
            portADir_r <= PORT_A_DIRECTION_RESET;
        end else if (wrDirA) begin
            portADir_r <= (regWrData[PORT_A_WIDTH-1:0] & portAImpl)
                | ~portAImpl;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || otherReset) begin
            portBDir_r <= PORT_B_DIRECTION_RESET;
        end else if (wrDirB) begin
            portBDir_r <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || otherReset) begin
            options_r <= OPTIONS_RESET;
        end else if (wrOptions) begin
            options_r <= regWrData;
        end
    end

    // ======================================================================
    // Change detector.
    // ======================================================================
    // Output pins are masked out of the comparison.
    assign mismatch = (portBSync_r[7:CHANGE_LOW_BIT] ^ snapshot_r)
        & portBDir_r[7:CHANGE_LOW_BIT];
    assign anyMismatch = |mismatch;

    // Early silicon loses a change that lands on the read cycle.
    assign changeSet = anyMismatch && !(EARLY_SILICON && rdPortB);

    // The snapshot takes the synchronised level that a read returns, so a
    // read always ends exactly the mismatch that software saw.
    always_ff @(posedge mclk) begin
        if (rst) begin
            snapshot_r <= '0;
        end else if (rdPortB || wrPortB) begin
            snapshot_r <= portBSync_r[7:CHANGE_LOW_BIT];
        end
    end

    // A set in the same cycle as a software clear wins, so a lasting
    // mismatch cannot be cleared away.
    always_ff @(posedge mclk) begin
        if (rst || otherReset) begin
            portChangeFlag_r <= 1'b0;
        end else if (changeSet) begin
            portChangeFlag_r <= 1'b1;
        end else if (wrIntCtl && !regWrData[PORT_CHANGE_FLAG_BIT]) begin
            portChangeFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || otherReset) begin
            portChangeEnable_r <= 1'b0;
        end else if (wrIntCtl) begin
            portChangeEnable_r <= regWrData[PORT_CHANGE_ENABLE_BIT];
        end
    end

    // The request is a level, so it also serves as the halt wake-up.
    always_ff @(posedge mclk) begin
        if (rst) begin
            portChangeIrq <= 1'b0;
        end else begin
            portChangeIrq <= portChangeFlag_r && portChangeEnable_r;
        end
    end

    // ======================================================================
    // Pin drivers.
    // ======================================================================
    // Port A: ordinary bits drive both levels, bit 4 only pulls low.
    genvar gi;
    generate
        for (gi = 0; gi < PORT_A_WIDTH; gi++) begin : genPortA
            always_ff @(posedge mclk) begin
                if (rst) begin
                    portAOut[gi] <= 1'b0;
                end else if (gi == TIMER_CLOCK_BIT) begin
                    portAOut[gi] <= 1'b0;
                end else begin
                    portAOut[gi] <= portALatch_r[gi];
                end
            end

            // A high latch bit on the open-drain pin releases it, so an
            // outside pull-up sets the level there.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    portAOe_n[gi] <= 1'b1;
                end else if (gi == TIMER_CLOCK_BIT) begin
                    portAOe_n[gi] <= portADir_r[gi]
                        || portALatch_r[gi];
                end else begin
                    portAOe_n[gi] <= portADir_r[gi];
                end
            end
        end
    endgenerate

    generate
        for (gi = 0; gi < PORT_B_WIDTH; gi++) begin : genPortB
            always_ff @(posedge mclk) begin
                if (rst) begin
                    portBOut[gi] <= 1'b0;
                    portBOe_n[gi] <= 1'b1;
                end else begin
                    portBOut[gi] <= portBLatch_r[gi];
                    portBOe_n[gi] <= portBDir_r[gi];
                end
            end

            // The pull-up follows the direction bit, so a driven pin never
            // fights its own pull-up.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    portBPullupEn[gi] <= 1'b0;
                end else begin
                    portBPullupEn[gi] <=
                        !options_r[PULLUP_DISABLE_N_BIT]
                        && portBDir_r[gi];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Alternate input functions.
    // ======================================================================
    // Schmitt buffering is a pad property; only the logic level comes here.
    always_ff @(posedge mclk) begin
        if (rst) begin
            timerExtClock <= 1'b0;
        end else begin
            timerExtClock <= portASync_r[TIMER_CLOCK_BIT];
        end
    end

    // The five-bit variant has no pin behind the select, so it idles high.
    always_ff @(posedge mclk) begin
        if (rst) begin
            slaveSelect_n <= 1'b1;
        end else begin
            slaveSelect_n <= !HAS_PORT_A_BIT5
                || portASync_r[SLAVE_SELECT_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            extInterrupt <= 1'b0;
        end else begin
            extInterrupt <= portBSync_r[EXT_INTERRUPT_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            progClock <= 1'b0;
        end else begin
            progClock <= portBSync_r[PROG_CLOCK_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            progData <= 1'b0;
        end else begin
            progData <= portBSync_r[PROG_DATA_BIT];
        end
    end

    // ======================================================================
    // Read port.
    // ======================================================================
    always_comb begin
        rdData_nxt = UNMAPPED_READ_VALUE;
        unique case (regAddr)
            PORT_A_PINS_OFS: begin
                rdData_nxt = {2'b00, portAPins};
            end
            PORT_B_PINS_OFS: begin
                rdData_nxt = portBSync_r;
            end
            INTERRUPT_CONTROL_OFS: begin
                rdData_nxt[PORT_CHANGE_FLAG_BIT] = portChangeFlag_r;
                rdData_nxt[PORT_CHANGE_ENABLE_BIT] = portChangeEnable_r;
            end
            TIMER_AND_PULLUP_OPTIONS_OFS: begin
                rdData_nxt = options_r;
            end
            PORT_A_DIRECTION_OFS: begin
                rdData_nxt = {2'b00, portADir_r & portAImpl};
            end
            PORT_B_DIRECTION_OFS: begin
                rdData_nxt = portBDir_r;
            end
            default: begin
                rdData_nxt = UNMAPPED_READ_VALUE;
            end
        endcase
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdData <= '0;
        end else if (regRdStb) begin
            regRdData <= rdData_nxt;
        end else begin
            regRdData <= '0;
        end
    end

endmodule : dual_gpio_port

// ---- rtl/gpio_pkg.sv ----
// Constants shared by the dual general-purpose port block.
package gpio_pkg;

    // ======================================================================
    // Register offsets.
    // ======================================================================
    localparam logic [7:0] PORT_A_PINS_OFS = 8'h05;
    localparam logic [7:0] PORT_B_PINS_OFS = 8'h06;
    localparam logic [7:0] INTERRUPT_CONTROL_OFS = 8'h0b;
    localparam logic [7:0] TIMER_AND_PULLUP_OPTIONS_OFS = 8'h81;
    localparam logic [7:0] PORT_A_DIRECTION_OFS = 8'h85;
    localparam logic [7:0] PORT_B_DIRECTION_OFS = 8'h86;

    // ======================================================================
    // Widths and field positions.
    // ======================================================================
    localparam int PORT_A_WIDTH = 6;
    localparam int PORT_B_WIDTH = 8;
    localparam int SLAVE_SELECT_BIT = 5;
    localparam int TIMER_CLOCK_BIT = 4;
    localparam int EXT_INTERRUPT_BIT = 0;
    localparam int PROG_CLOCK_BIT = 6;
    localparam int PROG_DATA_BIT = 7;
    localparam int CHANGE_LOW_BIT = 4;
    localparam int PULLUP_DISABLE_N_BIT = 7;
    localparam int PORT_CHANGE_FLAG_BIT = 0;
    localparam int PORT_CHANGE_ENABLE_BIT = 3;

    // ======================================================================
    // Reset values and the unmapped read value.
    // ======================================================================
    localparam logic [7:0] OPTIONS_RESET = 8'hff;
    localparam logic [5:0] PORT_A_DIRECTION_RESET = 6'h3f;
    localparam logic [7:0] PORT_B_DIRECTION_RESET = 8'hff;
    localparam logic [5:0] PORT_A_LATCH_RESET = 6'h00;
    localparam logic [7:0] PORT_B_LATCH_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

endpackage : gpio_pkg
